// ===== hw/bqe_counter.sv
// Event qualification and counter for queue activity and bus data activity.
`timescale 1ns/1ps
module bqe_counter #(
  parameter int NUM_ENT = 16
) (
  // Clock and reset.
  input  wire logic                         CORE_CLK_IN,
  input  wire logic                         RST_B_IN,
  // Configuration.
  input  wire bqe_pkg::bqe_cfg_s            CFG_IN,
  input  wire logic [3:0]                   MODEL_IN,
  input  wire logic                         CLEAR_IN,
  // Raw conditions.
  input  wire logic [NUM_ENT-1:0]           ENT_VALID_IN,
  input  wire bqe_pkg::bqe_entry_s [NUM_ENT-1:0] ENT_IN,
  input  wire bqe_pkg::bqe_strobe_s         STROBE_IN,
  input  wire logic                         PRIV_USER_IN,
  // Status.
  output logic [bqe_pkg::CNT_W-1:0]         COUNT_OUT,
  output logic [bqe_pkg::ENT_W-1:0]         ADDED_OUT,
  output logic                              HIT_OUT
);
  bqe_pkg::bqe_state_s st_r;
  bqe_pkg::bqe_state_s st_nxt;
  bqe_pkg::bqe_mode_e  mode;
  logic [NUM_ENT-1:0]  ent_hit;
  logic [5:0]          qual_sum;
  logic                bus_hit;
  logic                priv_unused;

  // Privilege level is deliberately not a term of any qualification.
  assign priv_unused = PRIV_USER_IN;

  always_comb begin
    mode = bqe_pkg::MODE_OFF;
    if (CFG_IN.enable) begin
      if (CFG_IN.cfg_sel == bqe_pkg::CFG_SEL_IOQ &&
          CFG_IN.event_sel[5:0] == bqe_pkg::ESEL_IOQ_ACT) begin
        mode = bqe_pkg::MODE_IOQ;
      end else if (CFG_IN.event_sel == bqe_pkg::ESEL_BUS_DATA) begin
        mode = bqe_pkg::MODE_BUS;
      end
    end
  end

  // Each valid entry that passes the mask terms is one qualifying transaction, line or chunk alike.
  always_comb begin
    logic [bqe_pkg::MASK_W-1:0] m;
    logic rt, rw, mt, ag, pf, rwsel;
    m = CFG_IN.event_mask;
    rt = 1'b0;
    rw = 1'b0;
    mt = 1'b0;
    ag = 1'b0;
    pf = 1'b0;
    rwsel = 1'b0;
    ent_hit = '0;
    for (int i = 0; i < NUM_ENT; i++) begin
      rt = (m[bqe_pkg::RTYPE_MSB:bqe_pkg::RTYPE_LSB] == ENT_IN[i].req_type);
      rw = (m[bqe_pkg::RD_BIT] & ENT_IN[i].is_read) | (m[bqe_pkg::WR_BIT] & ENT_IN[i].is_write);
      rwsel = m[bqe_pkg::RD_BIT] | m[bqe_pkg::WR_BIT];
      mt = rwsel ? 1'b1 : |(m[bqe_pkg::MEM_MSB:bqe_pkg::MEM_LSB] & ENT_IN[i].mem_type);
      ag = (m[bqe_pkg::OWN_BIT] & ENT_IN[i].own_agent) | (m[bqe_pkg::OTHER_BIT] & ~ENT_IN[i].own_agent);
      pf = ~ENT_IN[i].prefetch | m[bqe_pkg::PF_BIT];
      if (MODEL_IN >= bqe_pkg::MODEL_SPLIT) begin
        ent_hit[i] = ENT_VALID_IN[i] & rt & rw & mt & ag & pf;
      end else begin
        ent_hit[i] = ENT_VALID_IN[i] & ag & pf & (rt | rw | (~rwsel & mt));
      end
    end
  end

  always_comb begin
    qual_sum = '0;
    for (int i = 0; i < NUM_ENT; i++) begin
      qual_sum = qual_sum + {5'h00, ent_hit[i]};
    end
  end

  assign bus_hit = |({STROBE_IN.bsy_oth, STROBE_IN.bsy_own, STROBE_IN.bsy_drv,
                      STROBE_IN.rdy_oth, STROBE_IN.rdy_own, STROBE_IN.rdy_drv} &
                     CFG_IN.event_mask[bqe_pkg::BSY_OTH_BIT:bqe_pkg::RDY_DRV_BIT]);

  always_comb begin
    st_nxt = st_r;
    st_nxt.added = '0;
    st_nxt.hit = 1'b0;
    case (mode)
      bqe_pkg::MODE_IOQ: begin
        st_nxt.added = (qual_sum > {2'h0, bqe_pkg::ENT_CLIP}) ? bqe_pkg::ENT_CLIP : qual_sum[3:0];
        st_nxt.hit = (qual_sum != '0);
      end
      bqe_pkg::MODE_BUS: begin
        st_nxt.added = {3'h0, bus_hit};
        st_nxt.hit = bus_hit;
      end
      default: begin
        st_nxt.added = '0;
      end
    endcase
    if (CLEAR_IN) begin
      st_nxt.count = '0;
    end else begin
      st_nxt.count = st_r.count + {{(bqe_pkg::CNT_W-bqe_pkg::ENT_W){1'b0}}, st_nxt.added};
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign COUNT_OUT = st_r.count;
  assign ADDED_OUT = st_r.added;
  assign HIT_OUT = st_r.hit;

  // Steps of a counted or a quiet cycle.
  sequence quiet_cycle_s;
    !st_nxt.hit && !CLEAR_IN;
  endsequence

  sequence count_kept_s;
    COUNT_OUT == $past(COUNT_OUT);
  endsequence

  sequence ioq_cycle_s;
    mode == bqe_pkg::MODE_IOQ && !CLEAR_IN && qual_sum <= {2'h0, bqe_pkg::ENT_CLIP};
  endsequence

  sequence ioq_step_s;
    COUNT_OUT == $past(COUNT_OUT) + {{(bqe_pkg::CNT_W-6){1'b0}}, $past(qual_sum)};
  endsequence

  count_hold_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    quiet_cycle_s |=> count_kept_s)
    else $error("Counter moved without a qualified event.");
  ioq_count_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    ioq_cycle_s |=> ioq_step_s)
    else $error("Counter did not add the active entries.");
  added_exact_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (mode == bqe_pkg::MODE_IOQ && qual_sum <= 6'h0F) |=> (ADDED_OUT == $past(qual_sum[3:0])))
    else $error("Active entry sum below the clip not added as is.");
  hit_added_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    HIT_OUT == (ADDED_OUT != '0))
    else $error("Hit flag and added amount disagree.");
  bus_one_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (mode == bqe_pkg::MODE_BUS) |=> (ADDED_OUT == {3'h0, HIT_OUT}))
    else $error("Bus data activity added more than one.");
  bus_rdy_drv_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (mode == bqe_pkg::MODE_BUS && CFG_IN.event_mask[bqe_pkg::RDY_DRV_BIT] && STROBE_IN.rdy_drv) |=> HIT_OUT)
    else $error("Driven data ready strobe not counted.");
  bus_rdy_own_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (mode == bqe_pkg::MODE_BUS && CFG_IN.event_mask[bqe_pkg::RDY_OWN_BIT] && STROBE_IN.rdy_own) |=> HIT_OUT)
    else $error("Own data ready strobe not counted.");
  bus_bsy_oth_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (mode == bqe_pkg::MODE_BUS && CFG_IN.event_mask[bqe_pkg::BSY_OTH_BIT] && STROBE_IN.bsy_oth) |=> HIT_OUT)
    else $error("Other data busy strobe not counted.");
  off_hit_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (mode == bqe_pkg::MODE_OFF) |=> !HIT_OUT)
    else $error("Hit flagged while no event selected.");

  // Entry qualification checks, then clip, bus step, bus mask and idle checks, then more entry qualification checks and a clear check.
  invalid_ent_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    !ENT_VALID_IN[0] |-> !ent_hit[0])
    else $error("Idle queue entry counted.");
  strict_rw_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (MODEL_IN >= bqe_pkg::MODEL_SPLIT && ent_hit[0]) |->
    ((CFG_IN.event_mask[bqe_pkg::RD_BIT] & ENT_IN[0].is_read) | (CFG_IN.event_mask[bqe_pkg::WR_BIT] & ENT_IN[0].is_write)))
    else $error("New model hit without read or write match.");
  strict_agent_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (MODEL_IN >= bqe_pkg::MODEL_SPLIT && ent_hit[0]) |->
    (ENT_IN[0].own_agent ? CFG_IN.event_mask[bqe_pkg::OWN_BIT] : CFG_IN.event_mask[bqe_pkg::OTHER_BIT]))
    else $error("New model hit without source agent match.");
  loose_term_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (MODEL_IN < bqe_pkg::MODEL_SPLIT && ent_hit[0]) |->
    ((CFG_IN.event_mask[4:0] == ENT_IN[0].req_type) || (CFG_IN.event_mask[5] && ENT_IN[0].is_read) ||
     (CFG_IN.event_mask[6] && ENT_IN[0].is_write) ||
     (!CFG_IN.event_mask[5] && !CFG_IN.event_mask[6] && |(CFG_IN.event_mask[11:7] & ENT_IN[0].mem_type))))
    else $error("Old model hit without any qualifying term.");
  loose_memign_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (MODEL_IN < bqe_pkg::MODEL_SPLIT && (CFG_IN.event_mask[5] || CFG_IN.event_mask[6]) &&
     (CFG_IN.event_mask[4:0] != ENT_IN[0].req_type) && !(CFG_IN.event_mask[5] && ENT_IN[0].is_read) &&
     !(CFG_IN.event_mask[6] && ENT_IN[0].is_write)) |-> !ent_hit[0])
    else $error("Memory type bits used with read or write selected.");
  prefetch_gate_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (ent_hit[0] && ENT_IN[0].prefetch) |-> CFG_IN.event_mask[bqe_pkg::PF_BIT])
    else $error("Prefetch entry counted without its mask bit.");
  added_clip_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (mode == bqe_pkg::MODE_IOQ && qual_sum > 6'h0F) |=> (ADDED_OUT == bqe_pkg::ENT_CLIP))
    else $error("Active entry sum not clipped at fifteen.");
  bus_step_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (mode == bqe_pkg::MODE_BUS && !CLEAR_IN) |=> (COUNT_OUT == $past(COUNT_OUT) + $past({39'h0, bus_hit})))
    else $error("Bus data activity step wrong.");
  bus_mask_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (mode == bqe_pkg::MODE_BUS && (CFG_IN.event_mask[5:0] == 6'h00)) |=> !HIT_OUT)
    else $error("Bus event counted with empty mask.");
  off_idle_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (mode == bqe_pkg::MODE_OFF) |=> (ADDED_OUT == 4'h0))
    else $error("Counting while no event selected.");
  strict_and_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (MODEL_IN >= bqe_pkg::MODEL_SPLIT && ENT_VALID_IN[0] && ent_hit[0]) |->
    (CFG_IN.event_mask[4:0] == ENT_IN[0].req_type))
    else $error("New model hit without request type match.");
  loose_agent_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (MODEL_IN < 4'h2 && ent_hit[0]) |-> (ENT_IN[0].own_agent ? CFG_IN.event_mask[13] : CFG_IN.event_mask[14]))
    else $error("Old model hit without source agent match.");
  memtype_ign_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    (MODEL_IN >= 4'h2 && ENT_VALID_IN[0] && (CFG_IN.event_mask[4:0] == ENT_IN[0].req_type) && CFG_IN.event_mask[5]
     && ENT_IN[0].is_read && ENT_IN[0].own_agent && CFG_IN.event_mask[13] && !ENT_IN[0].prefetch) |-> ent_hit[0])
    else $error("Memory type bits not ignored with read selected.");
  clear_zero_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
    CLEAR_IN |=> (COUNT_OUT == '0))
    else $error("Clear did not zero the counter.");
endmodule

// ===== hw/bqe_pkg.sv
// Package with constants and carrier types for the bus queue event counter.
package bqe_pkg;
  localparam int          MASK_W          = 16;
  localparam int          CNT_W           = 40;
  localparam int          ENT_W           = 4;
  localparam logic [3:0]  ENT_CLIP        = 4'hF;
  localparam logic [2:0]  CFG_SEL_IOQ     = 3'h6;
  localparam logic [5:0]  ESEL_IOQ_ACT    = 6'h1A;
  localparam logic [6:0]  ESEL_BUS_DATA   = 7'h17;
  localparam logic [3:0]  MODEL_SPLIT     = 4'h2;
  localparam logic [4:0]  RTYPE_DEFAULT   = 5'h01;
  localparam int          RTYPE_LSB       = 0;
  localparam int          RTYPE_MSB       = 4;
  localparam int          RD_BIT          = 5;
  localparam int          WR_BIT          = 6;
  localparam int          MEM_LSB         = 7;
  localparam int          MEM_MSB         = 11;
  localparam int          OWN_BIT         = 13;
  localparam int          OTHER_BIT       = 14;
  localparam int          PF_BIT          = 15;
  localparam int          RDY_DRV_BIT     = 0;
  localparam int          RDY_OWN_BIT     = 1;
  localparam int          RDY_OTH_BIT     = 2;
  localparam int          BSY_DRV_BIT     = 3;
  localparam int          BSY_OWN_BIT     = 4;
  localparam int          BSY_OTH_BIT     = 5;

  // Software programmed event selection.
  typedef struct packed {
    logic [6:0]        event_sel;
    logic [MASK_W-1:0] event_mask;
    logic [2:0]        cfg_sel;
    logic              enable;
  } bqe_cfg_s;

  // Raw condition from one active queue entry source, per cycle.
  typedef struct packed {
    logic [4:0] req_type;
    logic       is_read;
    logic       is_write;
    logic [4:0] mem_type;
    logic       own_agent;
    logic       prefetch;
    logic       full_line;
  } bqe_entry_s;

  // Bus data strobes seen this cycle.
  typedef struct packed {
    logic rdy_drv;
    logic rdy_own;
    logic rdy_oth;
    logic bsy_drv;
    logic bsy_own;
    logic bsy_oth;
  } bqe_strobe_s;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_IOQ,
    MODE_BUS
  } bqe_mode_e;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [ENT_W-1:0] added;
    logic             hit;
  } bqe_state_s;
endpackage

// ===== test/bqe_far_model.sv
// Behavioural model of the bus queue entries that face the counter.
`timescale 1ns/1ps
module bqe_far_model (
  // Entry request.
  input  wire logic [4:0]            n_in,
  input  wire bqe_pkg::bqe_entry_s   ent_in,
  // Queue view.
  output logic [15:0]                valid_out,
  output bqe_pkg::bqe_entry_s [15:0] ent_out
);
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      valid_out[i] = i < int'(n_in);
      ent_out[i] = valid_out[i] ? ent_in : ~ent_in;
      ent_out[i].full_line = valid_out[i] & i[0];
    end
  end
endmodule

// ===== test/tb.sv
// Self-checking testbench for the bus queue event counter.
`timescale 1ns/1ps
module tb;
  logic                      clk = 1'b0;
  logic                      rst_b = 1'b0;
  logic                      clr = 1'b0;
  logic                      priv = 1'b0;
  logic [3:0]                model = 4'h0;
  logic [4:0]                n_act = 5'h00;
  bqe_pkg::bqe_cfg_s         cfg = '0;
  bqe_pkg::bqe_entry_s       ent = '0;
  bqe_pkg::bqe_strobe_s      stb = '0;
  logic [15:0]               valid;
  bqe_pkg::bqe_entry_s [15:0] ents;
  logic [39:0]               cnt;
  logic [3:0]                added;
  logic                      hit;
  logic [39:0]               exp_cnt = '0;
  int                        err_total = 0;
  int                        n_compared = 0;
  always #10 clk = ~clk;
  bqe_far_model u_far (.n_in(n_act), .ent_in(ent), .valid_out(valid), .ent_out(ents));
  bqe_counter #(.NUM_ENT(16)) u_dut (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .CFG_IN(cfg), .MODEL_IN(model),
    .CLEAR_IN(clr), .ENT_VALID_IN(valid), .ENT_IN(ents), .STROBE_IN(stb), .PRIV_USER_IN(priv),
    .COUNT_OUT(cnt), .ADDED_OUT(added), .HIT_OUT(hit));
  function automatic bqe_pkg::bqe_entry_s mk(logic [4:0] rt, logic rd, logic wr, logic [4:0] mt, logic ow, logic pf);
    return {rt, rd, wr, mt, ow, pf, 1'b0};
  endfunction
  task automatic chk(string what, logic [39:0] e, logic [39:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic step(logic [6:0] es, logic [2:0] cs, logic en, logic [3:0] md, logic [15:0] m,
                      bqe_pkg::bqe_entry_s e, logic [4:0] n, logic [5:0] sv);
    logic q, rt, rw, mm, ig, src, ok;
    logic [3:0] ea;
    q = en && cs == 3'h6 && es[5:0] == 6'h1A;
    rt = m[4:0] == e.req_type;
    rw = (m[5] & e.is_read) | (m[6] & e.is_write);
    mm = |(m[11:7] & e.mem_type);
    ig = m[5] | m[6];
    src = ((m[13] & e.own_agent) | (m[14] & ~e.own_agent)) & (~e.prefetch | m[15]);
    ok = (md >= 4'h2) ? (rt & rw & (ig | mm) & src) : ((rt | rw | (mm & ~ig)) & src);
    ea = q ? (ok ? ((n > 5'h0F) ? 4'hF : n[3:0]) : 4'h0) : {3'h0, en && es == 7'h17 && |(m[5:0] & sv)};
    @(posedge clk);
    cfg <= '{event_sel: es, event_mask: m, cfg_sel: cs, enable: en};
    model <= md;
    ent <= e;
    n_act <= n;
    stb <= {sv[0], sv[1], sv[2], sv[3], sv[4], sv[5]};
    priv <= ~priv;
    @(posedge clk);
    n_act <= 5'h00;
    stb <= '0;
    #1;
    exp_cnt = exp_cnt + 40'(ea);
    chk("added", 40'(ea), 40'(added));
    chk("hit", 40'(ea != 4'h0), 40'(hit));
    chk("count", exp_cnt, cnt);
  endtask
  task automatic qs(logic [3:0] md, logic [15:0] m, bqe_pkg::bqe_entry_s e, logic [4:0] n);
    step(7'h1A, 3'h6, 1'b1, md, m, e, n, 6'h00);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    qs(4'h2, 16'h2821, mk(5'h01, 1, 0, 5'h10, 1, 0), 5'h03);
    qs(4'h2, 16'h2821, mk(5'h01, 1, 0, 5'h10, 1, 0), 5'h10);
    qs(4'h2, 16'h2821, mk(5'h01, 1, 0, 5'h01, 1, 0), 5'h02);
    qs(4'h2, 16'h2821, mk(5'h02, 1, 0, 5'h10, 1, 0), 5'h02);
    qs(4'h1, 16'h2821, mk(5'h02, 1, 0, 5'h10, 1, 0), 5'h02);
    qs(4'h1, 16'h2821, mk(5'h01, 1, 0, 5'h10, 0, 0), 5'h02);
    qs(4'h0, 16'h2801, mk(5'h02, 0, 1, 5'h10, 1, 0), 5'h04);
    qs(4'h0, 16'h2821, mk(5'h02, 0, 1, 5'h10, 1, 0), 5'h04);
    qs(4'h2, 16'h2821, mk(5'h01, 1, 0, 5'h10, 1, 1), 5'h03);
    qs(4'h2, 16'hA821, mk(5'h01, 1, 0, 5'h10, 1, 1), 5'h03);
    qs(4'h2, 16'h4841, mk(5'h01, 0, 1, 5'h10, 0, 0), 5'h05);
    step(7'h1A, 3'h5, 1'b1, 4'h2, 16'h2821, mk(5'h01, 1, 0, 5'h10, 1, 0), 5'h03, 6'h00);
    step(7'h1A, 3'h6, 1'b0, 4'h2, 16'h2821, mk(5'h01, 1, 0, 5'h10, 1, 0), 5'h03, 6'h00);
    $display("test queue done");
    for (int i = 0; i < 6; i++) begin
      step(7'h17, 3'h0, 1'b1, 4'h2, 16'(1 << i), '0, 5'h00, 6'(1 << i));
    end
    step(7'h17, 3'h0, 1'b1, 4'h2, 16'h0001, '0, 5'h00, 6'h02);
    step(7'h16, 3'h0, 1'b1, 4'h2, 16'h0001, '0, 5'h00, 6'h01);
    $display("test bus done");
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    #1;
    exp_cnt = '0;
    chk("cleared", exp_cnt, cnt);
    $display("test clear done");
    give_verdict();
  end
endmodule
